// File: inc/sglpm_pkg.sv
// Package for the shared gpio, signal-loss and egress tap pin logic.
`default_nettype none
package sglpm_pkg;
   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam logic [15:0] gpio_state_high_byte_addr = 16'h0146;
   localparam logic [15:0] gpio_state_low_byte_addr = 16'h0147;
   localparam logic [15:0] gpio_direction_high_addr = 16'h014a;
   localparam logic [15:0] gpio_direction_low_addr = 16'h014b;
   localparam logic [7:0] dir_reset = 8'h00;
   localparam logic [7:0] state_reset = 8'h00;
   localparam int tap_pin = 3;
   localparam int pin_count = 12;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef enum logic {
      sglpm_tap_insert,
      sglpm_tap_extract
   } sglpm_tap_mode_t;

   typedef struct packed {
      logic pos;
      logic neg;
   } sglpm_rail_t;

   typedef struct packed {
      logic [15:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } sglpm_bus_t;
endpackage
`default_nettype wire

// File: logic/sglpm_pins.sv
// Shared pin logic: gpio, external signal loss inputs and egress tap port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Channel disabled: its pin is a register controlled gpio.
// - Low direction register holds direction bits for pins 0 to 7.
// - High direction register holds pins 8 upward, pin 8 at bit 0.
// - An input pin reads back its current level in the state register.
// - An output pin drives the value written to its state bit.
// - High state byte carries pins 8 upward, read and write.
// - Enabled channel: pin high declares loss of signal for it.
// - Channel 3 loss input only while the egress tap port is off.
// - Tap port on: channel 3 pin is negative rail, in or out.
// - Insert mode replaces the egress stream with the rail data.
// - Insert mode samples both rails on falling tap clock edges.
// - Extract mode changes both rails on rising tap clock edges.
module sglpm_pins #(
   parameter int npins = sglpm_pkg::pin_count
) (
   input wire logic clk,
   input wire logic rst,
   input wire sglpm_pkg::sglpm_bus_t bus,
   output logic [7:0] rdata,
   input wire logic [npins-1:0] chan_enable,
   input wire logic tap_enable,
   input wire sglpm_pkg::sglpm_tap_mode_t tap_mode,
   input wire logic [npins-1:0] pin_in,
   output logic [npins-1:0] pin_out,
   output logic [npins-1:0] pin_oe,
   output logic [npins-1:0] signal_loss,
   input wire logic egress_tap_clock_in,
   output logic egress_tap_clock_out,
   output logic egress_tap_clock_oe,
   input wire logic egress_tap_pos_rail_in,
   output logic egress_tap_pos_rail_out,
   output logic egress_tap_pos_rail_oe,
   input wire sglpm_pkg::sglpm_rail_t egress_data,
   output sglpm_pkg::sglpm_rail_t egress_stream,
   output logic egress_stream_valid
);
   // ----------------------------------------------------------------------
   // Synchronisers
   // ----------------------------------------------------------------------
   logic [npins+1:0] sync1, sync2;
   logic [npins-1:0] pin_s;
   logic clk_s, pos_s, clk_d;
   always_ff @(posedge clk) begin
      sync1 <= {egress_tap_clock_in, egress_tap_pos_rail_in, pin_in};
      sync2 <= sync1;
      clk_d <= clk_s;
   end
   assign pin_s = sync2[npins-1:0];
   assign pos_s = sync2[npins];
   assign clk_s = sync2[npins+1];

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   logic [15:0] dir, state, next_dir, next_state;
   logic tap_on;
   assign tap_on = tap_enable;
   always_comb begin
      next_dir = dir;
      next_state = state;
      if (bus.wr) begin
         if (bus.addr == sglpm_pkg::gpio_direction_low_addr) begin
            next_dir[7:0] = bus.wdata;
         end else if (bus.addr == sglpm_pkg::gpio_direction_high_addr) begin
            next_dir[15:8] = bus.wdata;
         end else if (bus.addr == sglpm_pkg::gpio_state_low_byte_addr) begin
            next_state[7:0] = bus.wdata;
         end else if (bus.addr == sglpm_pkg::gpio_state_high_byte_addr) begin
            next_state[15:8] = bus.wdata;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         dir <= {sglpm_pkg::dir_reset, sglpm_pkg::dir_reset};
         state <= {sglpm_pkg::state_reset, sglpm_pkg::state_reset};
      end else begin
         dir <= next_dir;
         state <= next_state;
      end
   end

   // Input pins read their level; output pins read the written value.
   logic [15:0] level;
   always_comb begin
      level = state;
      for (int i = 0; i < npins; i++) begin
         if (!dir[i]) begin
            level[i] = pin_s[i];
         end
      end
   end
   // Read data holds between reads; unknown addresses read as zero.
   logic [7:0] next_rdata;
   always_comb begin
      next_rdata = rdata;
      if (bus.rd) begin
         next_rdata = 8'h00;
         if (bus.addr == sglpm_pkg::gpio_direction_low_addr) begin
            next_rdata = dir[7:0];
         end else if (bus.addr == sglpm_pkg::gpio_direction_high_addr) begin
            next_rdata = dir[15:8];
         end else if (bus.addr == sglpm_pkg::gpio_state_low_byte_addr) begin
            next_rdata = level[7:0];
         end else if (bus.addr == sglpm_pkg::gpio_state_high_byte_addr) begin
            next_rdata = level[15:8];
         end
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= 8'h00;
      end else begin
         rdata <= next_rdata;
      end
   end

   // ----------------------------------------------------------------------
   // Pin function select
   // ----------------------------------------------------------------------
   logic tap_pin_out;
   always_comb begin
      for (int i = 0; i < npins; i++) begin
         pin_out[i] = state[i];
         pin_oe[i] = !chan_enable[i] && dir[i];
         signal_loss[i] = chan_enable[i] && pin_s[i];
      end
      if (tap_on) begin
         signal_loss[sglpm_pkg::tap_pin] = 1'b0;
         pin_out[sglpm_pkg::tap_pin] = tap_pin_out;
         pin_oe[sglpm_pkg::tap_pin] =
            (tap_mode == sglpm_pkg::sglpm_tap_extract);
      end
   end

   // ----------------------------------------------------------------------
   // Egress tap port
   // ----------------------------------------------------------------------
   // The tap clock is sampled on clk; it must run well below clk/4.
   logic fall, rise, insert, extract;
   assign fall = clk_d && !clk_s;
   assign rise = !clk_d && clk_s;
   assign insert = tap_on && tap_mode == sglpm_pkg::sglpm_tap_insert;
   assign extract = tap_on && tap_mode == sglpm_pkg::sglpm_tap_extract;

   sglpm_pkg::sglpm_rail_t next_stream, rails, next_rails;
   logic next_valid;
   always_comb begin
      next_stream = egress_stream;
      next_valid = 1'b0;
      next_rails = rails;
      if (insert && fall) begin
         next_stream.pos = pos_s;
         next_stream.neg = pin_s[sglpm_pkg::tap_pin];
         next_valid = 1'b1;
      end
      if (extract && rise) begin
         next_rails = egress_data;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         egress_stream <= '0;
         egress_stream_valid <= 1'b0;
         rails <= '0;
      end else begin
         egress_stream <= next_stream;
         egress_stream_valid <= next_valid;
         rails <= next_rails;
      end
   end
   assign tap_pin_out = rails.neg;
   assign egress_tap_pos_rail_out = rails.pos;
   assign egress_tap_pos_rail_oe = extract;
   assign egress_tap_clock_out = 1'b0;
   assign egress_tap_clock_oe = 1'b0;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence tap_fall_s;
      insert && fall;
   endsequence
   gpio_drive_a: assert property (!chan_enable[4] && dir[4]
      |-> pin_oe[4] && pin_out[4] == state[4])
      else $error("gpio output not driven");
   chan_los_a: assert property (chan_enable[4] && pin_s[4]
      |-> signal_loss[4])
      else $error("loss of signal not declared");
   gpio_input_a: assert property (chan_enable[1] |-> !pin_oe[1])
      else $error("enabled channel pin driven");
   tap_priority_a: assert property (tap_on
      |-> !signal_loss[sglpm_pkg::tap_pin])
      else $error("tap pin used as loss input");
   tap_sample_a: assert property (tap_fall_s
      |=> egress_stream_valid && egress_stream.pos == $past(pos_s))
      else $error("rail not sampled on falling edge");
   tap_neg_a: assert property (tap_fall_s
      |=> egress_stream.neg == $past(pin_s[3]))
      else $error("negative rail not sampled");
   tap_extract_a: assert property (extract && !rise
      |=> $stable(rails))
      else $error("rails changed off rising edge");
   tap_dir_a: assert property (tap_on
      |-> pin_oe[3] == (tap_mode == sglpm_pkg::sglpm_tap_extract))
      else $error("tap pin direction wrong");
   dir_write_a: assert property (bus.wr
      && bus.addr == sglpm_pkg::gpio_direction_high_addr
      |=> dir[15:8] == $past(bus.wdata))
      else $error("direction high not written");
   dir_low_a: assert property (bus.wr
      && bus.addr == sglpm_pkg::gpio_direction_low_addr
      |=> dir[7:0] == $past(bus.wdata))
      else $error("direction low not written");
   read_input_a: assert property (bus.rd && !dir[2]
      && bus.addr == sglpm_pkg::gpio_state_low_byte_addr
      |=> rdata[2] == $past(pin_s[2]))
      else $error("input level not read back");
   reset_dir_a: assert property ($past(rst) |-> dir == 16'h0000)
      else $error("pins not inputs after reset");
   high_read_a: assert property (bus.rd && dir[8]
      && bus.addr == sglpm_pkg::gpio_state_high_byte_addr
      |=> rdata[0] == $past(state[8]))
      else $error("high byte read wrong");
endmodule
`default_nettype wire

// File: dv/sglpm_tap_src.sv
// Far side of the egress tap port: tap clock and dual-rail data source.
`timescale 1ns/1ps
`default_nettype none
module sglpm_tap_src (
   input wire logic run,
   input wire logic [1:0] pattern,
   output logic tap_clk,
   output logic pos,
   output logic neg
);
   initial begin
      tap_clk = 1'b0;
      pos = 1'b0;
      neg = 1'b1;
      #7;
      forever begin
         #100;
         if (run) begin
            tap_clk = ~tap_clk;
            // Rails move on the rise so they are steady at the fall.
            if (tap_clk) {pos, neg} = pattern;
         end else begin
            // Outside frames the clock stands still and the rails wander.
            {pos, neg} = ~{pos, neg};
         end
      end
   end
endmodule
`default_nettype wire

// File: dv/tb_sglpm_pins.sv
// Self-checking bench for the shared gpio, signal-loss and tap pin logic.
`timescale 1ns/1ps
`default_nettype none
module tb_sglpm_pins;
   logic clk, rst, tap_en, src_on, tclk, pos, neg, prail, poe, svalid;
   logic pos_w, tco, tcoe;
   logic [1:0] pat;
   logic [7:0] rdata, d;
   logic [11:0] chan_en, ext, ext_w, pin_in, pin_out, pin_oe, loss;
   sglpm_pkg::sglpm_bus_t bus;
   sglpm_pkg::sglpm_tap_mode_t mode;
   sglpm_pkg::sglpm_rail_t edata, stream;
   int error_cnt = 0;
   int samples_checked = 0;
   int cycles = 0;
   int n;
   assign ext_w = {ext[11:4], src_on ? neg : ext[3], ext[2:0]};
   // A wire shows the design's value only while it drives it.
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_w);
   assign pos_w = poe ? prail : pos;
   sglpm_pins dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
      .chan_enable(chan_en), .tap_enable(tap_en), .tap_mode(mode),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .signal_loss(loss), .egress_tap_clock_in(tclk),
      .egress_tap_clock_out(tco), .egress_tap_clock_oe(tcoe),
      .egress_tap_pos_rail_in(pos_w), .egress_tap_pos_rail_out(prail),
      .egress_tap_pos_rail_oe(poe), .egress_data(edata),
      .egress_stream(stream), .egress_stream_valid(svalid));
   sglpm_tap_src src (.run(src_on), .pattern(pat), .tap_clk(tclk),
      .pos(pos), .neg(neg));
   // ---------------------------------------------------------------
   // Clock, timeout and shared tasks
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         final_report();
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      bus = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
      @(posedge clk) #2;
      bus.wr = 1'b0;
      // An idle cycle keeps the strobes of back-to-back calls apart.
      @(posedge clk) #2;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      bus = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(posedge clk) #2;
      bus.rd = 1'b0;
      chk(rdata, exp);
      @(posedge clk) #2;
   endtask
   task automatic settle();
      repeat (4) @(posedge clk) #2;
   endtask
   task automatic catch_sample();
      for (n = 0; n < 40 && svalid !== 1'b1; n++) @(posedge clk) #2;
      chk(svalid, 1'b1);
      @(posedge clk) #2;
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      chk(pin_oe, 12'h000);
      rd(16'h014b, 8'h00);
      rd(16'h014a, 8'h00);
      rd(16'h0148, 8'h00);
   endtask
   task automatic t_gpio();
      wr(16'h0147, 8'h9c);
      wr(16'h014b, 8'hf0);
      wr(16'h0146, 8'h53);
      wr(16'h014a, 8'h05);
      settle();
      chk(pin_oe, 12'h5f0);
      chk(pin_out & pin_oe, 12'h190);
      rd(16'h0147, 8'h9a);
      rd(16'h0146, 8'h5b);
      chan_en = 12'hfff;
      settle();
      chk(pin_oe, 12'h000);
      chk(loss, 12'ha5a);
      chan_en = 12'h000;
      settle();
      chk(loss, 12'h000);
      chk(pin_oe, 12'h5f0);
   endtask
   task automatic t_insert();
      chan_en = 12'h008;
      tap_en = 1'b1;
      src_on = 1'b1;
      for (int p = 0; p < 4; p++) begin
         pat = p[1:0];
         catch_sample();
         catch_sample();
         chk(stream, pat);
         chk(loss[3], 1'b0);
         chk(pin_oe[3], 1'b0);
      end
   endtask
   task automatic t_extract();
      mode = sglpm_pkg::sglpm_tap_extract;
      edata = 2'b10;
      @(posedge tclk);
      @(negedge tclk);
      @(posedge clk) #2;
      chk({poe, pin_oe[3]}, 2'b11);
      chk({tco, tcoe}, 2'b00);
      chk({prail, pin_out[3]}, 2'b10);
      edata = 2'b01;
      repeat (3) @(posedge clk) #2;
      chk({prail, pin_out[3]}, 2'b10);
      @(posedge tclk);
      repeat (5) @(posedge clk) #2;
      chk({prail, pin_out[3]}, 2'b01);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      rst = 1'b1;
      bus = '0;
      chan_en = 12'h000;
      tap_en = 1'b0;
      mode = sglpm_pkg::sglpm_tap_insert;
      ext = 12'ha5a;
      edata = '0;
      src_on = 1'b0;
      pat = 2'b00;
      repeat (3) @(posedge clk);
      #2;
      rst = 1'b0;
      t_reset();
      t_gpio();
      t_insert();
      t_extract();
      final_report();
   end
endmodule
`default_nettype wire
